// [src/ebpm_top.sv]
// external bus pin multiplexer: mode straps, ports a/b/e muxing, bus clock
// assumes core request fields stay stable from bus_req until bus_ack
`timescale 1ns/10ps
`default_nettype none
module ebpm_top (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        single_wire_debug_pin,
   input  wire logic [7:0]  pa_pin_in,
   input  wire logic [7:0]  pb_pin_in,
   input  wire logic [7:0]  pe_pin_in,
   output var  logic [7:0]  pa_pin_out,
   output var  logic [7:0]  pa_pin_oe,
   output var  logic [7:0]  pb_pin_out,
   output var  logic [7:0]  pb_pin_oe,
   output var  logic [7:0]  pe_pin_out,
   output var  logic [7:0]  pe_pin_oe,
   input  wire logic        bus_req,
   input  wire logic [15:0] bus_addr,
   input  wire logic [15:0] bus_wdata,
   input  wire logic        bus_read,
   input  wire logic        bus_byte,
   output var  logic        bus_ack,
   output var  logic [15:0] bus_rdata,
   output var  logic        tag_upper_half,
   input  wire logic        tagging_enable,
   input  wire logic        pipe_status_bit1,
   input  wire logic        pipe_status_bit0,
   input  wire logic        pipe_status_output_enable,
   input  wire logic        system_clock_test,
   input  wire logic        clock_test_enable,
   input  wire logic        internal_visibility_enable,
   input  wire logic        bus_clock_free_run,
   input  wire logic [1:0]  bus_clock_stretch,
   input  wire logic [7:0]  port_a_data_register,
   input  wire logic [7:0]  port_a_direction_register,
   input  wire logic [7:0]  port_b_data_register,
   input  wire logic [7:0]  port_b_direction_register,
   input  wire logic [7:0]  port_e_data_register,
   input  wire logic [7:0]  port_e_direction_register,
   output var  logic        mode_select_high,
   output var  logic        mode_select_mid,
   output var  logic        mode_select_low,
   output var  logic [7:0]  port_a_pin_value,
   output var  logic [7:0]  port_b_pin_value,
   output var  logic [7:0]  port_e_pin_value
);
   typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} ebpm_state_t;

   logic [2:0]  strap_s;
   localparam int PE_IDX6 = ebpm_pkg::PE_PIPE1;
   localparam int PE_IDX5 = ebpm_pkg::PE_PIPE0;
   ebpm_sync #(.W(8)) u_sync_a (.clk(clk), .rstn(rstn), .d(pa_pin_in),
                                .q(port_a_pin_value));
   ebpm_sync #(.W(8)) u_sync_b (.clk(clk), .rstn(rstn), .d(pb_pin_in),
                                .q(port_b_pin_value));
   ebpm_sync #(.W(8)) u_sync_e (.clk(clk), .rstn(rstn), .d(pe_pin_in),
                                .q(port_e_pin_value));
   ebpm_sync #(.W(3)) u_sync_m (.clk(clk), .rstn(rstn),
      .d({single_wire_debug_pin, pe_pin_in[PE_IDX6], pe_pin_in[PE_IDX5]}),
      .q(strap_s));

   // strap capture and mode decode
   logic [2:0]  mode_q, mode_d;
   logic        done_q, done_d;
   logic [1:0]  wait_q, wait_d;
   logic        master, wide, narrow, special, periph;

   always_comb begin
      mode_d = mode_q;
      done_d = done_q;
      wait_d = wait_q;
      if (!done_q) begin
         // pins need the synchroniser depth before they can be trusted
         if (wait_q == ebpm_pkg::STRAP_WAIT_CYC) begin
            mode_d = strap_s;
            done_d = 1'b1;
         end else begin
            wait_d = wait_q + 2'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= ebpm_pkg::MODE_RESET;
         done_q <= 1'b0;
         wait_q <= 2'h0;
      end else begin
         mode_q <= mode_d;
         done_q <= done_d;
         wait_q <= wait_d;
      end
   end

   assign mode_select_high = mode_q[ebpm_pkg::MODE_HIGH_BIT];
   assign mode_select_mid  = mode_q[ebpm_pkg::MODE_MID_BIT];
   assign mode_select_low  = mode_q[ebpm_pkg::MODE_LOW_BIT];

   always_comb begin
      narrow = (mode_q == ebpm_pkg::MODE_EMUL_NARROW) ||
               (mode_q == ebpm_pkg::MODE_NORM_NARROW);
      wide   = (mode_q == ebpm_pkg::MODE_SPEC_TEST) ||
               (mode_q == ebpm_pkg::MODE_EMUL_WIDE) ||
               (mode_q == ebpm_pkg::MODE_NORM_WIDE);
      periph = (mode_q == ebpm_pkg::MODE_SPEC_PERIPH);
      master = done_q && (narrow || wide);
      special = !mode_q[ebpm_pkg::MODE_HIGH_BIT] || periph;
   end

   // bus cycle sequencer
   ebpm_state_t st_q, st_d;
   logic [3:0]  cnt_q, cnt_d;
   logic        beat_q, beat_d, act_q, act_d, two_q, two_d, wx_q, wx_d;
   logic        rd_q, rd_d, byte_q, byte_d, bus_timing_clock_q, bus_timing_clock_d;
   logic        ack_d, tag_d;
   logic [15:0] addr_q, addr_d, wd_q, wd_d, rdata_d;
   logic [3:0]  high_last;

   always_comb begin
      st_d = st_q;  cnt_d = cnt_q;  beat_d = beat_q;  act_d = act_q;
      two_d = two_q;  wx_d = wx_q;  rd_d = rd_q;  byte_d = byte_q;
      addr_d = addr_q;  wd_d = wd_q;  rdata_d = bus_rdata;
      bus_timing_clock_d = bus_timing_clock_q;  ack_d = 1'b0;  tag_d = 1'b0;
      high_last = ebpm_pkg::HIGH_MIN_CYC - 4'h1 + {2'h0, bus_clock_stretch};
      case (st_q)
         ST_IDLE: begin
            if (master && (bus_req || bus_clock_free_run)) begin
               st_d   = ST_LOW;
               act_d  = bus_req;
               addr_d = bus_addr;
               wd_d   = bus_wdata;
               rd_d   = bus_read;
               byte_d = bus_byte;
               // visible word accesses in emulation narrow use both ports
               wx_d   = !bus_byte && (wide ||
                        (internal_visibility_enable &&
                         mode_q == ebpm_pkg::MODE_EMUL_NARROW));
               two_d  = !bus_byte && !wx_d;
               beat_d = 1'b0;
            end
         end
         ST_LOW: begin
            st_d   = ST_HIGH;
            bus_timing_clock_d = 1'b1;
            cnt_d  = 4'h0;
         end
         ST_HIGH: begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q >= high_last) begin
               bus_timing_clock_d = 1'b0;
               if (act_q && rd_q) begin
                  if (wx_q) begin
                     rdata_d = {port_a_pin_value, port_b_pin_value};
                  end else if (beat_q || (byte_q && addr_q[0])) begin
                     rdata_d[7:0] = port_a_pin_value;
                  end else begin
                     rdata_d[15:8] = port_a_pin_value;
                  end
                  tag_d = tagging_enable && !beat_q && !strap_s[2];
               end
               if (two_q && !beat_q) begin
                  beat_d = 1'b1;
                  st_d   = ST_LOW;
               end else begin
                  ack_d = act_q;
                  act_d = 1'b0;
                  st_d  = ST_IDLE;
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // pin drive, computed from next state so that pins track the bus clock
   logic [7:0]  pa_d, pa_oe_d, pb_d, pb_oe_d, pe_d, pe_oe_d;
   logic [15:0] pin_addr;

   always_comb begin
      pin_addr = {addr_d[15:1], addr_d[0] | beat_d};
      pa_d = port_a_data_register;
      pa_oe_d = port_a_direction_register;
      pb_d = port_b_data_register;
      pb_oe_d = port_b_direction_register;
      pe_d = port_e_data_register;
      pe_oe_d = port_e_direction_register;
      pe_oe_d[1:0] = 2'h0;
      pe_d[1:0] = 2'h0;
      if (!done_q || periph) begin
         // before the straps are caught nothing may load the mode pins
         pa_oe_d = ebpm_pkg::BYTE_ZERO;
         pb_oe_d = ebpm_pkg::BYTE_ZERO;
      end else if (master) begin
         pa_d = pin_addr[15:8];
         pb_d = pin_addr[7:0];
         pa_oe_d = ebpm_pkg::BYTE_ONES;
         pb_oe_d = ebpm_pkg::BYTE_ONES;
         if (st_d == ST_HIGH && act_d) begin
            if (wx_d) begin
               pa_d = wd_d[15:8];
               pb_d = wd_d[7:0];
               pb_oe_d = rd_d ? ebpm_pkg::BYTE_ZERO : ebpm_pkg::BYTE_ONES;
            end else begin
               pa_d = pin_addr[0] ? wd_d[7:0] : wd_d[15:8];
            end
            pa_oe_d = rd_d ? ebpm_pkg::BYTE_ZERO : ebpm_pkg::BYTE_ONES;
         end
      end
      if (!done_q) begin
         pe_oe_d = ebpm_pkg::BYTE_ZERO;
      end else begin
         if (master) begin
            pe_d[ebpm_pkg::PE_FREE]  = !act_d;
            pe_d[ebpm_pkg::PE_BCLK]  = bus_timing_clock_d;
            pe_d[ebpm_pkg::PE_LOW_BYTE_STROBE] = !wx_d;
            pe_d[ebpm_pkg::PE_RW]    = !act_d || rd_d;
            pe_oe_d[ebpm_pkg::PE_FREE]  = 1'b1;
            pe_oe_d[ebpm_pkg::PE_BCLK]  = 1'b1;
            pe_oe_d[ebpm_pkg::PE_LOW_BYTE_STROBE] = 1'b1;
            pe_oe_d[ebpm_pkg::PE_RW]    = 1'b1;
         end else if (periph) begin
            // the tester drives size and direction in this mode
            pe_oe_d[ebpm_pkg::PE_LOW_BYTE_STROBE] = 1'b0;
            pe_oe_d[ebpm_pkg::PE_RW]    = 1'b0;
         end
         if (pipe_status_output_enable) begin
            pe_d[ebpm_pkg::PE_PIPE1]    = pipe_status_bit1;
            pe_d[ebpm_pkg::PE_PIPE0]    = pipe_status_bit0;
            pe_oe_d[ebpm_pkg::PE_PIPE1] = 1'b1;
            pe_oe_d[ebpm_pkg::PE_PIPE0] = 1'b1;
         end else if (special && clock_test_enable) begin
            pe_d[ebpm_pkg::PE_PIPE1]    = system_clock_test;
            pe_oe_d[ebpm_pkg::PE_PIPE1] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= ST_IDLE;  cnt_q <= 4'h0;  beat_q <= 1'b0;  act_q <= 1'b0;
         two_q <= 1'b0;  wx_q <= 1'b0;  rd_q <= 1'b1;  byte_q <= 1'b0;
         addr_q <= 16'h0000;  wd_q <= 16'h0000;  bus_timing_clock_q <= 1'b0;
         bus_ack <= 1'b0;  bus_rdata <= 16'h0000;  tag_upper_half <= 1'b0;
         pa_pin_out <= 8'h00;  pa_pin_oe <= 8'h00;
         pb_pin_out <= 8'h00;  pb_pin_oe <= 8'h00;
         pe_pin_out <= 8'h00;  pe_pin_oe <= 8'h00;
      end else begin
         st_q <= st_d;  cnt_q <= cnt_d;  beat_q <= beat_d;  act_q <= act_d;
         two_q <= two_d;  wx_q <= wx_d;  rd_q <= rd_d;  byte_q <= byte_d;
         addr_q <= addr_d;  wd_q <= wd_d;  bus_timing_clock_q <= bus_timing_clock_d;
         bus_ack <= ack_d;  bus_rdata <= rdata_d;  tag_upper_half <= tag_d;
         pa_pin_out <= pa_d;  pa_pin_oe <= pa_oe_d;
         pb_pin_out <= pb_d;  pb_pin_oe <= pb_oe_d;
         pe_pin_out <= pe_d;  pe_pin_oe <= pe_oe_d;
      end
   end

   // checks
   property p_mode_high;
      @(posedge clk) disable iff (!rstn)
      $rose(done_q) |-> mode_select_high == $past(strap_s[2]);
   endproperty
   a_mode_high: assert property (p_mode_high)
      else $error("mode high bit not captured from strap");
   property p_mode_mid;
      @(posedge clk) disable iff (!rstn)
      $rose(done_q) |-> mode_select_mid == $past(strap_s[1]);
   endproperty
   a_mode_mid: assert property (p_mode_mid)
      else $error("mode mid bit not captured from strap");
   property p_mode_low;
      @(posedge clk) disable iff (!rstn)
      $rose(done_q) |-> mode_select_low == $past(strap_s[0]);
   endproperty
   a_mode_low: assert property (p_mode_low)
      else $error("mode low bit not captured from strap");
   property p_mode_hold;
      @(posedge clk) disable iff (!rstn)
      done_q |=> done_q && $stable(mode_q);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode bits changed after capture");
   property p_addr_low;
      @(posedge clk) disable iff (!rstn)
      st_q == ST_LOW |-> pa_pin_oe == 8'hFF && !bus_timing_clock_q &&
         pa_pin_out == {addr_q[15:8]} && pb_pin_oe == 8'hFF;
   endproperty
   a_addr_low: assert property (p_addr_low)
      else $error("address not driven in low phase");
   property p_turn;
      @(posedge clk) disable iff (!rstn)
      st_q == ST_LOW |=> bus_timing_clock_q && st_q == ST_HIGH;
   endproperty
   a_turn: assert property (p_turn)
      else $error("bus clock did not rise after address phase");
   property p_read_dir;
      @(posedge clk) disable iff (!rstn)
      st_q == ST_HIGH && act_q && rd_q |-> pa_pin_oe == 8'h00 &&
         pe_pin_out[ebpm_pkg::PE_RW];
   endproperty
   a_read_dir: assert property (p_read_dir)
      else $error("port a driven during read data phase");
   property p_pipe;
      @(posedge clk) disable iff (!rstn)
      done_q && pipe_status_output_enable |=> pe_pin_oe[6] &&
         pe_pin_out[6] == $past(pipe_status_bit1) &&
         pe_pin_out[5] == $past(pipe_status_bit0);
   endproperty
   a_pipe: assert property (p_pipe)
      else $error("pipe status not on port e");
   property p_free;
      @(posedge clk) disable iff (!rstn)
      master && $past(master) |-> pe_pin_out[7] == !act_q;
   endproperty
   a_free: assert property (p_free)
      else $error("free cycle indicator wrong");
   property p_high_len;
      @(posedge clk) disable iff (!rstn)
      $rose(bus_timing_clock_q) |-> bus_timing_clock_q [*3];
   endproperty
   a_high_len: assert property (p_high_len)
      else $error("bus clock high phase too short");
   c_wide_write: cover property (@(posedge clk) disable iff (!rstn)
      bus_ack && wx_q && !rd_q);
   c_narrow_read: cover property (@(posedge clk) disable iff (!rstn)
      bus_ack && two_q && rd_q);
   c_tag: cover property (@(posedge clk) disable iff (!rstn)
      tag_upper_half);
endmodule // ebpm_top
`default_nettype wire

// [src/ebpm_pkg.sv]
// constants for the external bus pin multiplexer
// assumes one 40 MHz core clock; every pin passes a two-flop synchroniser
package ebpm_pkg;
   // captured mode codes, {high, mid, low}
   localparam logic [2:0] MODE_SPEC_SINGLE = 3'h0;
   localparam logic [2:0] MODE_EMUL_NARROW = 3'h1;
   localparam logic [2:0] MODE_SPEC_TEST   = 3'h2;
   localparam logic [2:0] MODE_EMUL_WIDE   = 3'h3;
   localparam logic [2:0] MODE_NORM_SINGLE = 3'h4;
   localparam logic [2:0] MODE_NORM_NARROW = 3'h5;
   localparam logic [2:0] MODE_SPEC_PERIPH = 3'h6;
   localparam logic [2:0] MODE_NORM_WIDE   = 3'h7;
   localparam logic [2:0] MODE_RESET       = 3'h0;
   // strap bit positions
   localparam int MODE_HIGH_BIT = 2;
   localparam int MODE_MID_BIT  = 1;
   localparam int MODE_LOW_BIT  = 0;
   // port e bit positions
   localparam int PE_FREE  = 7;
   localparam int PE_PIPE1 = 6;
   localparam int PE_PIPE0 = 5;
   localparam int PE_BCLK  = 4;
   localparam int PE_LOW_BYTE_STROBE = 3;
   localparam int PE_RW    = 2;
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int HIGH_MIN_NS   = 75;
   localparam logic [3:0] HIGH_MIN_CYC =
      4'((HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] STRAP_WAIT_CYC = 2'h2;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
endpackage

// [src/ebpm_sync.sv]
// two-flop synchroniser for pin inputs
// assumes d is asynchronous to clk; only q may be read
`timescale 1ns/10ps
`default_nettype none
module ebpm_sync #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // ebpm_sync
`default_nettype wire

// [test/ebpm_mem_model.sv]
// external memory on the far side of the multiplexed address/data bus
// assumes the bench resolves pin levels from the dut's output enables
`timescale 1ns/10ps
`default_nettype none
module ebpm_mem_model (
   input  wire logic       clk,
   input  wire logic [7:0] pa_pin_out,
   input  wire logic [7:0] pa_pin_oe,
   input  wire logic [7:0] pb_pin_out,
   input  wire logic [7:0] pe_pin_out,
   input  wire logic [7:0] pe_pin_oe,
   output var  logic [7:0] pa_drv,
   output var  logic [7:0] pb_drv
);
   logic [7:0]  mem [0:65535];
   logic [15:0] addr_q;
   logic        bclk;
   logic        rd;
   logic        both;
   logic [15:0] pin_addr;
   assign bclk = pe_pin_out[ebpm_pkg::PE_BCLK] & pe_pin_oe[ebpm_pkg::PE_BCLK];
   assign rd   = pe_pin_out[ebpm_pkg::PE_RW] | ~pe_pin_oe[ebpm_pkg::PE_RW];
   assign both = ~pe_pin_out[ebpm_pkg::PE_LOW_BYTE_STROBE] & pe_pin_oe[ebpm_pkg::PE_LOW_BYTE_STROBE];
   initial begin
      addr_q = 16'h0000;
      pa_drv = 8'h00;
      pb_drv = 8'h00;
      foreach (mem[i]) mem[i] = 8'h00;
   end
   assign pin_addr = {pa_pin_out, pb_pin_out};
   always @(posedge clk) begin
      if (bclk && !rd) begin
         mem[addr_q] <= pa_pin_out;
         if (both) mem[addr_q | 16'h0001] <= pb_pin_out;
      end
      if (!bclk && pa_pin_oe === 8'hFF) begin
         addr_q <= pin_addr;
         // read data set up from the address phase: the pins pass two
         // flops inside and are taken in the last high cycle
         pa_drv <= rd ? mem[pin_addr] : ~pa_drv;
         pb_drv <= (rd && both) ? mem[pin_addr | 16'h0001]
                                : ~pb_drv;
      end else begin
         // a released lane shows the inverse so stale data never passes
         pa_drv <= (bclk && rd) ? mem[addr_q] : ~pa_drv;
         pb_drv <= (bclk && rd && both) ? mem[addr_q | 16'h0001]
                                        : ~pb_drv;
      end
   end
endmodule // ebpm_mem_model
`default_nettype wire

// [test/external_bus_pin_multiplexer_tb_top.sv]
// bench for the external bus pin multiplexer, memory model on the pins
// assumes the design samples inputs on the rising edge of a 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
module external_bus_pin_multiplexer_tb_top;
   logic clk = 1'b0, rstn = 1'b0, single_wire_debug_pin = 1'b1;
   logic [7:0] pe_ext = 8'h00, pa_drv, pb_drv, pa_pin_in, pb_pin_in;
   logic [7:0] pe_pin_in, pa_pin_out, pa_pin_oe, pb_pin_out, pb_pin_oe;
   logic [7:0] pe_pin_out, pe_pin_oe, port_a_pin_value, port_b_pin_value;
   logic [7:0] port_e_pin_value;
   logic bus_req = 1'b0, bus_read = 1'b0, bus_byte = 1'b0, bus_ack;
   logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, bus_rdata;
   logic tag_upper_half, tagging_enable = 1'b0, pipe_status_bit1 = 1'b0;
   logic pipe_status_bit0 = 1'b0, pipe_status_output_enable = 1'b0;
   logic system_clock_test = 1'b0, clock_test_enable = 1'b0;
   logic internal_visibility_enable = 1'b0, bus_clock_free_run = 1'b0;
   logic [1:0] bus_clock_stretch = 2'h0;
   logic [7:0] port_a_data_register = 8'h00, port_a_direction_register = 8'h00;
   logic [7:0] port_b_data_register = 8'h00, port_b_direction_register = 8'h00;
   logic [7:0] port_e_data_register = 8'h00, port_e_direction_register = 8'h00;
   logic mode_select_high, mode_select_mid, mode_select_low;
   logic [7:0] ref_mem [0:15];
   int miscompares = 0, comparisons = 0, tag_cnt = 0, m;
   assign pa_pin_in = (pa_pin_oe & pa_pin_out) | (~pa_pin_oe & pa_drv);
   assign pb_pin_in = (pb_pin_oe & pb_pin_out) | (~pb_pin_oe & pb_drv);
   assign pe_pin_in = (pe_pin_oe & pe_pin_out) | (~pe_pin_oe & pe_ext);
   ebpm_top dut (.clk, .rstn, .single_wire_debug_pin, .pa_pin_in, .pb_pin_in,
      .pe_pin_in, .pa_pin_out, .pa_pin_oe, .pb_pin_out, .pb_pin_oe,
      .pe_pin_out, .pe_pin_oe, .bus_req, .bus_addr, .bus_wdata, .bus_read,
      .bus_byte, .bus_ack, .bus_rdata, .tag_upper_half, .tagging_enable,
      .pipe_status_bit1, .pipe_status_bit0, .pipe_status_output_enable,
      .system_clock_test, .clock_test_enable, .internal_visibility_enable,
      .bus_clock_free_run, .bus_clock_stretch, .port_a_data_register,
      .port_a_direction_register, .port_b_data_register,
      .port_b_direction_register, .port_e_data_register,
      .port_e_direction_register, .mode_select_high, .mode_select_mid,
      .mode_select_low, .port_a_pin_value, .port_b_pin_value,
      .port_e_pin_value);
   ebpm_mem_model mem (.clk, .pa_pin_out, .pa_pin_oe, .pb_pin_out,
      .pe_pin_out, .pe_pin_oe, .pa_drv, .pb_drv);
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      #2 system_clock_test <= ~system_clock_test;
      if (tag_upper_half === 1'b1) tag_cnt++;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic do_reset(input logic [2:0] md);
      @(posedge clk);
      #2 rstn = 1'b0;
      single_wire_debug_pin = md[2];
      pe_ext[6:5] = md[1:0];
      repeat (10) @(posedge clk);
      #2 rstn = 1'b1;
      repeat (4) @(posedge clk);
      #2 single_wire_debug_pin = 1'b1;
      pe_ext[6:5] = ~md[1:0];
      repeat (3) @(posedge clk);
      #2 check({13'h0000, mode_select_high, mode_select_mid, mode_select_low},
         {13'h0000, md});
   endtask
   // request held with its fields until the edge that shows the ack
   task automatic acc(input logic rd, input logic byt, input logic [15:0] a,
      input logic [15:0] wd, output logic [15:0] got, output int n);
      @(posedge clk);
      #2 bus_req = 1'b1;
      bus_addr = a;
      bus_wdata = wd;
      bus_read = rd;
      bus_byte = byt;
      n = 0;
      do begin
         @(posedge clk);
         #2 n++;
      end while (bus_ack !== 1'b1 && n < 40);
      got = bus_rdata;
      bus_req = 1'b0;
   endtask
   task automatic op(input logic rd, input logic byt, input logic [15:0] a);
      logic [15:0] wd, got;
      logic [3:0]  k;
      int          n;
      wd = 16'($urandom);
      k = a[3:0];
      bus_clock_stretch = 2'($urandom_range(0, 3));
      acc(rd, byt, a, wd, got, n);
      check({15'h0000, n < 40}, 16'h0001);
      if (!byt && rd) check(got, {ref_mem[k], ref_mem[k | 4'h1]});
      else if (!byt) {ref_mem[k], ref_mem[k | 4'h1]} = wd;
      else if (rd) check({8'h00, a[0] ? got[7:0] : got[15:8]},
         {8'h00, ref_mem[k]});
      else ref_mem[k] = a[0] ? wd[7:0] : wd[15:8];
   endtask
   task automatic run_ops(input int cnt);
      int i;
      logic [15:0] a;
      logic byt;
      for (i = 0; i < cnt; i++) begin
         a = 16'($urandom_range(0, 15));
         byt = 1'($urandom);
         if (!byt) a[0] = 1'b0;
         op(i < 8 ? 1'b0 : 1'($urandom), byt, a);
      end
   endtask
   task automatic pipe_chk(input logic special);
      int i;
      clock_test_enable = 1'b1;
      repeat (3) @(posedge clk);
      #2 check({14'h0000, pe_pin_oe[6], pe_pin_out[6]},
         {14'h0000, special, special & system_clock_test});
      pipe_status_output_enable = 1'b1;
      for (i = 0; i < 4; i++) begin
         {pipe_status_bit1, pipe_status_bit0} = 2'(i);
         repeat (3) @(posedge clk);
         #2 check({12'h0000, pe_pin_oe[6:5], pe_pin_out[6:5]},
            {12'h0000, 2'h3, 2'(i)});
      end
      pipe_status_output_enable = 1'b0;
      clock_test_enable = 1'b0;
   endtask
   task automatic refused();
      logic [15:0] got;
      int n;
      acc(1'b1, 1'b0, 16'h0000, 16'h0000, got, n);
      check({15'h0000, n == 40}, 16'h0001);
   endtask
   initial begin
      // the tests need under two thousand cycles; this leaves ample margin
      #500_000;
      miscompares++;
      print_verdict();
   end
   initial begin
      int rises, i;
      logic ones, prev;
      void'($urandom(32'h80c2_6c5f));
      foreach (ref_mem[j]) ref_mem[j] = 8'h00;
      pe_ext[1:0] = 2'($urandom);
      for (m = 0; m < 8; m++) do_reset(3'(m));
      do_reset(ebpm_pkg::MODE_NORM_SINGLE);
      {port_a_data_register, port_b_data_register} = 16'($urandom);
      {port_a_direction_register, port_b_direction_register} = 16'($urandom);
      repeat (3) @(posedge clk);
      #2 check({pa_pin_oe, pb_pin_oe}, {port_a_direction_register,
         port_b_direction_register});
      check({pa_pin_out & pa_pin_oe, pb_pin_out & pb_pin_oe},
         {port_a_data_register & port_a_direction_register,
          port_b_data_register & port_b_direction_register});
      check({14'h0000, port_e_pin_value[1:0]}, {14'h0000, pe_ext[1:0]});
      pipe_chk(1'b0);
      refused();
      do_reset(ebpm_pkg::MODE_SPEC_TEST);
      pipe_chk(1'b1);
      do_reset(ebpm_pkg::MODE_SPEC_PERIPH);
      refused();
      check({pa_pin_oe, pb_pin_oe}, 16'h0000);
      do_reset(ebpm_pkg::MODE_NORM_WIDE);
      bus_clock_free_run = 1'b1;
      rises = 0;
      ones = 1'b1;
      prev = pe_pin_out[4];
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         #2 ones &= pe_pin_out[7];
         if (pe_pin_out[4] && !prev) rises++;
         prev = pe_pin_out[4];
      end
      check({14'h0000, ones, rises >= 2}, 16'h0003);
      bus_clock_free_run = 1'b0;
      run_ops(30);
      tagging_enable = 1'b1;
      single_wire_debug_pin = 1'b0;
      i = tag_cnt;
      op(1'b1, 1'b0, 16'h0004);
      // the tag pulse is counted 2 ns after the edge that shows it
      @(posedge clk);
      #2 check({15'h0000, tag_cnt > i}, 16'h0001);
      single_wire_debug_pin = 1'b1;
      i = tag_cnt;
      op(1'b1, 1'b0, 16'h0006);
      @(posedge clk);
      #2 check({15'h0000, tag_cnt > i}, 16'h0000);
      tagging_enable = 1'b0;
      do_reset(ebpm_pkg::MODE_EMUL_WIDE);
      run_ops(12);
      do_reset(ebpm_pkg::MODE_NORM_NARROW);
      run_ops(30);
      internal_visibility_enable = 1'b1;
      do_reset(ebpm_pkg::MODE_EMUL_NARROW);
      run_ops(20);
      print_verdict();
   end
endmodule // external_bus_pin_multiplexer_tb_top
`default_nettype wire
